// ===== haptic_playback_sequencer.sv
// Real-time playback path and eight-slot effect sequencer with Wishbone registers
// Operation
// RULE_01: In real-time mode with fire set, drive the real-time amplitude to the load.
// RULE_02: Host may rewrite real-time amplitude anytime; each written value is used. Code uses only the value held when each update period ends.
// RULE_03: Real-time amplitude is treated as an eight-bit two's complement number.
// RULE_04: Slot with wait flag set idles ten milliseconds per count, playing nothing.
// RULE_05: Slot with wait flag clear holds an effect identifier to play.
// RULE_06: Effect identifier selects the library effect at that index.
// RULE_07: Fire in sequencer mode starts playback at slot address 0x0f.
// RULE_08: After a slot finishes, advance to next address if that entry is non-zero.
// RULE_09: Stop at the first zero slot or after the slot at 0x16.
// RULE_10: All later slots decode wait flag and field like the first slot.
// RULE_11: Fire bit stays set until the process completes, then self-clears.
// RULE_12: Host clearing fire during playback abandons playback at once.
// RULE_13: Library strength scaling is ignored in real-time mode.
// RULE_14: Real-time amplitude is resampled every update period while active.
`include "haptic_seq_regs.svh"
module haptic_playback_sequencer #(
  parameter int WAIT_UNIT = `WAIT_UNIT_CYC,
  parameter int UPDATE_PERIOD = `UPDATE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic effect_start,
  input wire logic effect_done,
  output logic drive_valid,
  input wire logic drive_ready,
  output haptic_seq_pkg::drive_word_t drive_data
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0][7:0] slots;
    logic [7:0] rt_amp;
    logic [1:0] gain;
    haptic_seq_pkg::play_mode_t mode;
    logic fire;
    haptic_seq_pkg::play_state_t st;
    logic [2:0] slot_idx;
    logic [6:0] wait_cnt;
    logic [23:0] tick;
    logic [31:0] rdata;
    logic ack;
    logic start;
    logic [1:0] fill;
    haptic_seq_pkg::drive_word_t [1:0] buf_q;
    haptic_seq_pkg::drive_word_t out_w;
    logic out_v;
    logic rt_seen;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] wbyte;
  logic [7:0] cur_slot;
  logic push;
  haptic_seq_pkg::drive_word_t push_w;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; answer one cycle after the request, never twice in a row
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !s_reg.ack;
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack;
  assign wbyte = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
  assign cur_slot = s_reg.slots[s_reg.slot_idx];
  assign pop = s_reg.out_v && drive_ready;

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    push = 1'b0;
    push_w = '0;
    s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
    s_next.start = 1'b0;
    // Register writes; only the low byte lane carries data
    if (wr_stb && wb_sel_i[0]) begin
      if (wb_adr_i == (`RT_AMP_IDX << 2)) begin
        s_next.rt_amp = wbyte; // RULE_02
        s_next.rt_seen = 1'b1;
      end
      if (wb_adr_i == (`STRENGTH_CFG_IDX << 2)) begin
        s_next.gain = wbyte[1:0];
      end
      if (wb_adr_i == (`MODE_CFG_IDX << 2)) begin
        s_next.mode = haptic_seq_pkg::play_mode_t'(wbyte[1:0]);
      end
      if (wb_adr_i == (`FIRE_CTRL_IDX << 2)) begin
        s_next.fire = wbyte[`FIRE_BIT];
      end
      for (int i = 0; i < 8; i++) begin
        if (wb_adr_i == 8'((`SLOT_FIRST_IDX + i) << 2)) begin
          s_next.slots[i] = wbyte;
        end
      end
    end
    // Register reads; unmapped words read zero
    s_next.rdata = 32'h0000_0000;
    if (rd_stb) begin
      case (wb_adr_i)
        (`FIRE_CTRL_IDX << 2): s_next.rdata = {31'h0, s_reg.fire};
        (`STRENGTH_CFG_IDX << 2): s_next.rdata = {30'h0, s_reg.gain};
        (`RT_AMP_IDX << 2): s_next.rdata = {24'h0, s_reg.rt_amp};
        (`MODE_CFG_IDX << 2): s_next.rdata = {30'h0, s_reg.mode};
        (`STATUS_IDX << 2): s_next.rdata = {24'h0, 2'h0, s_reg.slot_idx, s_reg.st};
        default: begin
          for (int i = 0; i < 8; i++) begin
            if (wb_adr_i == 8'((`SLOT_FIRST_IDX + i) << 2)) begin
              s_next.rdata = {24'h0, s_reg.slots[i]};
            end
          end
        end
      endcase
    end
    // Playback engine
    if (s_reg.tick != 24'h0) begin
      s_next.tick = s_reg.tick - 24'h1;
    end
    if (!s_reg.fire) begin
      s_next.st = haptic_seq_pkg::ST_IDLE; // RULE_12
    end else begin
      case (s_reg.st)
        haptic_seq_pkg::ST_IDLE: begin
          s_next.slot_idx = 3'h0; // RULE_07
          s_next.st = (s_reg.mode == haptic_seq_pkg::MODE_RT) ? haptic_seq_pkg::ST_RT
                    : haptic_seq_pkg::ST_LOAD;
          s_next.tick = 24'h0;
          s_next.rt_seen = 1'b1;
          if (s_reg.mode == haptic_seq_pkg::MODE_OFF) begin
            s_next.fire = 1'b0;
            s_next.st = haptic_seq_pkg::ST_IDLE;
          end
        end
        haptic_seq_pkg::ST_LOAD: begin
          if (cur_slot == 8'h00) begin
            s_next.fire = 1'b0; // RULE_09 RULE_11
            s_next.st = haptic_seq_pkg::ST_IDLE;
          end else if (cur_slot[`SLOT_FLAG_BIT]) begin
            s_next.wait_cnt = cur_slot[6:0]; // RULE_04 RULE_10
            s_next.tick = 24'(WAIT_UNIT - 1);
            s_next.st = haptic_seq_pkg::ST_WAIT;
          end else if (s_reg.fill < 2'h2) begin
            push = 1'b1; // RULE_05 RULE_06
            push_w.effect = cur_slot[6:0];
            push_w.is_effect = 1'b1;
            push_w.level = 8'h7f >> s_reg.gain;
            s_next.start = 1'b1;
            s_next.st = haptic_seq_pkg::ST_PLAY;
          end
        end
        haptic_seq_pkg::ST_PLAY, haptic_seq_pkg::ST_WAIT: begin
          if (s_reg.st == haptic_seq_pkg::ST_WAIT && s_reg.wait_cnt != 7'h0 &&
              s_reg.tick == 24'h0) begin
            s_next.wait_cnt = s_reg.wait_cnt - 7'h1;
            s_next.tick = 24'(WAIT_UNIT - 1);
          end
          if ((s_reg.st == haptic_seq_pkg::ST_PLAY && effect_done) ||
              (s_reg.st == haptic_seq_pkg::ST_WAIT && s_reg.wait_cnt == 7'h0)) begin
            if (s_reg.slot_idx == 3'h7) begin
              s_next.fire = 1'b0; // RULE_09 RULE_11
              s_next.st = haptic_seq_pkg::ST_IDLE;
            end else begin
              s_next.slot_idx = s_reg.slot_idx + 3'h1; // RULE_08
              s_next.st = haptic_seq_pkg::ST_LOAD;
            end
          end
        end
        haptic_seq_pkg::ST_RT: begin
          // Resample each period; gain deliberately not applied here
          if (s_reg.tick == 24'h0 && s_reg.fill < 2'h2) begin
            push = 1'b1; // RULE_01 RULE_13 RULE_14
            push_w.level = s_reg.rt_amp; // RULE_03
            s_next.tick = 24'(UPDATE_PERIOD - 1);
            s_next.rt_seen = 1'b0;
          end
          if (s_reg.mode != haptic_seq_pkg::MODE_RT) begin
            s_next.fire = 1'b0;
            s_next.st = haptic_seq_pkg::ST_IDLE;
          end
        end
        default: s_next.st = haptic_seq_pkg::ST_IDLE;
      endcase
    end
    // Fire written high by host wins over self-clear
    if (wr_stb && wb_sel_i[0] && wb_adr_i == (`FIRE_CTRL_IDX << 2)) begin
      s_next.fire = wbyte[`FIRE_BIT];
    end
    // Two-entry buffer toward the drive stage; stalls the engine when full
    if (pop) begin
      s_next.out_v = 1'b0;
    end
    if (s_reg.fill != 2'h0 && (!s_reg.out_v || pop)) begin
      s_next.out_w = s_reg.buf_q[0];
      s_next.out_v = 1'b1;
      s_next.buf_q[0] = s_reg.buf_q[1];
      s_next.fill = s_reg.fill - 2'h1;
    end
    if (push) begin
      s_next.buf_q[s_next.fill[0]] = push_w;
      s_next.fill = s_next.fill + 2'h1;
    end
  end

  // Register the whole state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.rt_amp <= `RT_AMP_RESET;
      s_reg.slots[0] <= `SLOT_ONE_RESET;
      s_reg.st <= haptic_seq_pkg::ST_IDLE;
      s_reg.mode <= haptic_seq_pkg::MODE_OFF;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdata;
  assign effect_start = s_reg.start;
  assign drive_valid = s_reg.out_v;
  assign drive_data = s_reg.out_w;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  stop_on_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.st == haptic_seq_pkg::ST_LOAD && s_reg.fire && cur_slot == 8'h00
    |=> !s_reg.fire && s_reg.st == haptic_seq_pkg::ST_IDLE) // RULE_09
    else $error("sequencer did not stop on zero slot");
  cancel_fire_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_reg.fire && !$rose(s_reg.fire) |=> s_reg.st == haptic_seq_pkg::ST_IDLE) // RULE_12
    else $error("playback continued after fire cleared");
  start_first_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(s_reg.st) == haptic_seq_pkg::ST_IDLE && s_reg.st == haptic_seq_pkg::ST_LOAD
    |-> s_reg.slot_idx == 3'h0) // RULE_07
    else $error("playback did not start at first slot");
  advance_slot_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.fire && s_reg.st == haptic_seq_pkg::ST_PLAY && effect_done && s_reg.slot_idx != 3'h7
    |=> s_reg.slot_idx == $past(s_reg.slot_idx) + 3'h1) // RULE_08
    else $error("slot index did not advance");
  last_slot_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.fire && s_reg.st == haptic_seq_pkg::ST_PLAY && effect_done && s_reg.slot_idx == 3'h7
    |=> !s_reg.fire) // RULE_09 RULE_11
    else $error("sequence ran past last slot");
  wait_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.fire && s_reg.st == haptic_seq_pkg::ST_LOAD && cur_slot[7] && cur_slot != 8'h00
    |=> s_reg.st == haptic_seq_pkg::ST_WAIT && s_reg.wait_cnt == $past(cur_slot[6:0])
    && !s_reg.start) // RULE_04 RULE_10
    else $error("wait slot decoded wrongly");
  effect_id_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.start |-> s_reg.st == haptic_seq_pkg::ST_PLAY && s_reg.fill != 2'h0) // RULE_05 RULE_06
    else $error("effect start without effect word");
  rt_sample_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.fire && s_reg.st == haptic_seq_pkg::ST_RT && s_reg.mode == haptic_seq_pkg::MODE_RT
    && s_reg.tick == 24'h0 && s_reg.fill == 2'h0 && !s_reg.out_v
    |-> ##2 drive_valid && drive_data.level == $past(s_reg.rt_amp, 2)) // RULE_01 RULE_03 RULE_13 RULE_14
    else $error("real-time amplitude not driven unscaled");
  buf_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.fill <= 2'h2) // RULE_02
    else $error("drive buffer overflow");

  ////////////////////////////////////////////////////////////////////////////
  // Bus, stream and engine checks
  // Ack is a single pulse, so back-to-back requests cannot be taken twice
  ack_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood two cycles");
  // Every taken request is answered on the next edge
  ack_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !s_reg.ack |=> wb_ack_o)
    else $error("request not answered");
  // A written amplitude is held at once for the engine
  amp_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_stb && wb_sel_i[0] && wb_adr_i == (`RT_AMP_IDX << 2)
    |=> s_reg.rt_amp == $past(wb_dat_i[7:0])) // RULE_02
    else $error("amplitude write lost");
  // First slot keeps what the host wrote
  slot_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_stb && wb_sel_i[0] && wb_adr_i == (`SLOT_FIRST_IDX << 2)
    |=> s_reg.slots[0] == $past(wb_dat_i[7:0])) // RULE_05
    else $error("slot write lost");
  // No effect pulse can come out of idle
  idle_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.st == haptic_seq_pkg::ST_IDLE |-> !s_reg.start) // RULE_12
    else $error("effect start while idle");
  // A wait slot plays nothing
  wait_silent_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.st == haptic_seq_pkg::ST_WAIT |-> !push) // RULE_04
    else $error("word pushed during wait");
  // Real-time words carry no effect index
  rt_plain_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push && s_reg.st == haptic_seq_pkg::ST_RT |-> !push_w.is_effect) // RULE_01
    else $error("real-time word marked as effect");
  // Strength scaling never touches real-time words
  rt_unscaled_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push && s_reg.st == haptic_seq_pkg::ST_RT |-> push_w.level == s_reg.rt_amp) // RULE_13
    else $error("real-time word scaled");
  // Fire stays up while an effect is still running
  fire_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.fire && s_reg.st == haptic_seq_pkg::ST_PLAY && !effect_done
    && !(wr_stb && wb_adr_i == (`FIRE_CTRL_IDX << 2)) |=> s_reg.fire) // RULE_11
    else $error("fire dropped during effect");
  // Fire with no mode selected clears itself
  mode_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.fire && s_reg.st == haptic_seq_pkg::ST_IDLE && s_reg.mode == haptic_seq_pkg::MODE_OFF
    && !(wr_stb && wb_adr_i == (`FIRE_CTRL_IDX << 2)) |=> !s_reg.fire) // RULE_11
    else $error("fire stuck with mode off");
  // A stalled word stays put until the sink takes it
  drive_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    drive_valid && !drive_ready |=> drive_valid && $stable(drive_data))
    else $error("drive word changed under stall");
  // Each delay unit counts down by one
  wait_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.fire && s_reg.st == haptic_seq_pkg::ST_WAIT && s_reg.wait_cnt != 7'h0
    && s_reg.tick == 24'h0 |=> s_reg.wait_cnt == $past(s_reg.wait_cnt) - 7'h1) // RULE_04
    else $error("wait count skipped");
  // Sampling period restarts after every real-time sample
  rt_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.fire && s_reg.st == haptic_seq_pkg::ST_RT && s_reg.tick == 24'h0
    && s_reg.fill < 2'h2 |=> s_reg.tick == 24'(UPDATE_PERIOD - 1)) // RULE_14
    else $error("update period not restarted");
endmodule

// ===== haptic_seq_regs.svh
// Register offsets, reset values and timing counts of the playback sequencer
`ifndef HAPTIC_SEQ_REGS_SVH
`define HAPTIC_SEQ_REGS_SVH
`define FIRE_CTRL_IDX 8'h0c
`define STRENGTH_CFG_IDX 8'h0d
`define RT_AMP_IDX 8'h0e
`define SLOT_FIRST_IDX 8'h0f
`define SLOT_LAST_IDX 8'h16
`define MODE_CFG_IDX 8'h20
`define STATUS_IDX 8'h21
`define RT_AMP_RESET 8'h7f
`define SLOT_ONE_RESET 8'h01
`define SLOT_OTHER_RESET 8'h00
`define SLOT_FLAG_BIT 7
`define FIRE_BIT 0
`define WAIT_UNIT_MS 10
`define CLK_KHZ 10000
`define WAIT_UNIT_CYC (`WAIT_UNIT_MS * `CLK_KHZ)
`define UPDATE_PERIOD_US 1000
`define UPDATE_CYC (`UPDATE_PERIOD_US * `CLK_KHZ / 1000)
`endif

// ===== haptic_seq_pkg.sv
// Types shared by the playback sequencer
package haptic_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOAD = 3'h1,
    ST_PLAY = 3'h3,
    ST_WAIT = 3'h2,
    ST_RT = 3'h6
  } play_state_t;
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_SEQ = 2'h1,
    MODE_RT = 2'h2
  } play_mode_t;
  // One word of drive output
  typedef struct packed {
    logic [7:0] level;
    logic [6:0] effect;
    logic is_effect;
  } drive_word_t;
endpackage

// ===== drive_sink.sv
// Load side model: stalling drive sink and library effect player
module drive_sink #(
  parameter int DONE_LAT = 5
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic drive_valid,
  output logic drive_ready,
  input haptic_seq_pkg::drive_word_t drive_data,
  input wire logic effect_start,
  output logic effect_done
);
  timeunit 1ns;
  timeprecision 1ns;
  haptic_seq_pkg::drive_word_t words[$];
  time stamps[$];
  int starts;
  int lat;
  logic [1:0] ph;
  // Stall one cycle in four, so the buffer really has to hold words
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      drive_ready <= 1'b0;
      effect_done <= 1'b0;
      lat <= 0;
    end else begin
      ph <= ph + 2'h1;
      drive_ready <= (ph != 2'h2);
      if (drive_valid && drive_ready) begin
        words.push_back(drive_data);
        stamps.push_back($time);
      end
      effect_done <= (lat == 1);
      if (effect_start) begin
        starts <= starts + 1;
        lat <= DONE_LAT;
      end else if (lat != 0) begin
        lat <= lat - 1;
      end
    end
  end
endmodule

// ===== haptic_playback_sequencer_tb_top.sv
// Self-checking bench of the playback sequencer
module haptic_playback_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h1;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic start;
  logic done;
  logic dvalid;
  logic dready;
  haptic_seq_pkg::drive_word_t dword;
  int err_count = 0;
  int check_count = 0;
  haptic_playback_sequencer #(.WAIT_UNIT(10), .UPDATE_PERIOD(8)) haptic_playback_sequencer_inst (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .effect_start(start), .effect_done(done), .drive_valid(dvalid),
    .drive_ready(dready), .drive_data(dword));
  drive_sink drive_sink_inst (
    .mclk(mclk), .rst_n(rst_n), .drive_valid(dvalid), .drive_ready(dready),
    .drive_data(dword), .effect_start(start), .effect_done(done));
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns
  initial begin
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle; ack looked at on the rising edge, request held until then
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      err_count++;
    end
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_fire_clear;
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h30, 8'h00, q);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    chk(q, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic reset_values;
    logic [7:0] q;
    wb(1'b0, 8'h38, 8'h00, q);
    chk(q, 8'h7f);
    wb(1'b0, 8'h3c, 8'h00, q);
    chk(q, 8'h01);
    wb(1'b0, 8'hfc, 8'h00, q);
    chk(q, 8'h00);
  endtask
  // Negative amplitude, strength at its lowest, then a live rewrite and abort
  task automatic realtime_run;
    logic [7:0] q;
    wb(1'b1, 8'h34, 8'h03, q);
    wb(1'b1, 8'h38, 8'h80, q);
    wb(1'b1, 8'h80, 8'h02, q);
    drive_sink_inst.words.delete();
    wb(1'b1, 8'h30, 8'h01, q);
    repeat (40) @(posedge mclk);
    chk(drive_sink_inst.words[0], 16'h8000);
    wb(1'b0, 8'h30, 8'h00, q);
    chk(q, 8'h01);
    wb(1'b1, 8'h38, 8'h05, q);
    repeat (40) @(posedge mclk);
    chk(drive_sink_inst.words[$], 16'h0500);
    wb(1'b1, 8'h30, 8'h00, q);
    repeat (10) @(posedge mclk);
    drive_sink_inst.words.delete();
    repeat (40) @(posedge mclk);
    chk(drive_sink_inst.words.size(), 16'h0);
  endtask
  // Effect, wait of two units, effect, then a zero slot
  task automatic sequence_run;
    logic [7:0] q;
    int s;
    wb(1'b1, 8'h34, 8'h00, q);
    wb(1'b1, 8'h80, 8'h01, q);
    wb(1'b1, 8'h3c, 8'h03, q);
    wb(1'b1, 8'h40, 8'h82, q);
    wb(1'b1, 8'h44, 8'h05, q);
    wb(1'b1, 8'h48, 8'h00, q);
    drive_sink_inst.words.delete();
    drive_sink_inst.stamps.delete();
    s = drive_sink_inst.starts;
    wb(1'b1, 8'h30, 8'h01, q);
    wait_fire_clear();
    chk(drive_sink_inst.words.size(), 16'h2);
    chk(16'(drive_sink_inst.starts - s), 16'h2);
    chk(drive_sink_inst.words[0], 16'h7f07);
    chk(drive_sink_inst.words[1], 16'h7f0b);
    chk(16'(drive_sink_inst.stamps[1] - drive_sink_inst.stamps[0] >= 2000), 16'h1);
  endtask
  // Every slot holds an effect, so the last slot ends the run
  task automatic all_slots;
    logic [7:0] q;
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, 8'(8'h3c + 4 * i), 8'(i + 1), q);
    end
    drive_sink_inst.words.delete();
    wb(1'b1, 8'h30, 8'h01, q);
    wait_fire_clear();
    chk(drive_sink_inst.words.size(), 16'h8);
    chk(drive_sink_inst.words[7], 16'h7f11);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence after four cycles of reset
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    reset_values();
    realtime_run();
    sequence_run();
    all_slots();
    close_out();
  end
  // Watchdog: the whole run needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    close_out();
  end
endmodule
